// ===== hw/cadtr_cfg.svh
// Register offsets, field positions, reset values and masks of the tuning register group
`ifndef CADTR_CFG_SVH
`define CADTR_CFG_SVH

`define CADTR_ADDR_MUTE 8'h4b
`define CADTR_ADDR_ADC_PT 8'h4e
`define CADTR_ADDR_DAC_PT 8'h4f
`define CADTR_ADDR_CH1 8'h50

`define CADTR_RESET_VAL 8'h00

`define CADTR_MASK_MUTE 8'h18
`define CADTR_MASK_ADC_PT 8'he4
`define CADTR_MASK_DAC_PT 8'ha6
`define CADTR_MASK_CH1 8'hc3

`define CADTR_BIT_CH1_MUTE 4
`define CADTR_BIT_CH2_MUTE 3
`define CADTR_BIT_MOD_HALF 7
`define CADTR_BIT_CIC_ORDER 6
`define CADTR_BIT_FIR_SKIP 5
`define CADTR_BIT_ECO_FILT 2
`define CADTR_BIT_IREF_HALVE 1
`define CADTR_BIT_INSRC_HI 7
`define CADTR_BIT_INSRC_LO 6
`define CADTR_BIT_RANGE 1
`define CADTR_BIT_BW 0

`define CADTR_SAMPLE_W 24

`endif

// ===== hw/cadtr_pkg.sv
// Types shared by the codec tuning register group
package cadtr_pkg;

    typedef struct packed {
        logic adc_modulator_half_rate;
        logic adc_decimator_order_sel;
        logic adc_fir_skip;
        logic adc_economy_filter_en;
    } cadtr_adc_tune_t;

    typedef struct packed {
        logic dac_modulator_half_rate;
        logic dac_fir_segmenter_skip;
        logic dac_economy_filter_en;
        logic dac_ref_current_halve;
    } cadtr_dac_tune_t;

    typedef struct packed {
        logic [1:0] first_channel_input_type;
        logic first_channel_range_sel;
        logic first_channel_bandwidth_sel;
    } cadtr_ch1_cfg_t;

    typedef struct packed {
        logic [23:0] first_sample;
        logic [23:0] second_sample;
        logic valid;
    } cadtr_samples_t;

endpackage

// ===== hw/cadtr_sample_mute.sv
// Per-channel sample muting while an ADC channel recovers from overload
`timescale 1ns/1ps
`include "cadtr_cfg.svh"
module cadtr_sample_mute
    import cadtr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [1:0] mute_en_i,
    input wire logic [1:0] recovering_i,
    input wire cadtr_samples_t samples_i,
    output cadtr_samples_t samples_o
);

    wire [1:0] mute_now = mute_en_i & recovering_i;
    wire [`CADTR_SAMPLE_W-1:0] first_w;
    wire [`CADTR_SAMPLE_W-1:0] second_w;

    // Zero, not hold, so a recovering channel never repeats a clipped sample
    assign first_w = mute_now[0] ? '0 : samples_i.first_sample;
    assign second_w = mute_now[1] ? '0 : samples_i.second_sample;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            samples_o <= '0;
        else
            samples_o <= '{first_sample: first_w, second_sample: second_w,
                           valid: samples_i.valid};
    end

    a_first_mute_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (mute_en_i[0] && recovering_i[0]) |=> samples_o.first_sample == '0)
        else $error("channel 1 not muted in recovery");
    a_second_mute_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (mute_en_i[1] && recovering_i[1]) |=> samples_o.second_sample == '0)
        else $error("channel 2 not muted in recovery");
    a_first_pass_through: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !(mute_en_i[0] && recovering_i[0])
        |=> samples_o.first_sample == $past(samples_i.first_sample))
        else $error("channel 1 sample altered");
    a_second_pass_through: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !(mute_en_i[1] && recovering_i[1])
        |=> samples_o.second_sample == $past(samples_i.second_sample))
        else $error("channel 2 sample altered");

    c_first_muted: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        mute_en_i[0] && recovering_i[0] ##1 !recovering_i[0]);

endmodule

// ===== hw/cadtr_tuning_regs.sv
// Codec ADC/DAC tuning register group with overload-recovery muting
`timescale 1ns/1ps
`include "cadtr_cfg.svh"
module cadtr_tuning_regs
    import cadtr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_hit_o,
    input wire logic [1:0] overload_recovery_i,
    input wire cadtr_samples_t adc_samples_i,
    output cadtr_samples_t adc_samples_o,
    output logic [1:0] overload_mute_en_o,
    output cadtr_adc_tune_t adc_tune_o,
    output cadtr_dac_tune_t dac_tune_o,
    output cadtr_ch1_cfg_t ch1_cfg_o
);

    logic [7:0] mute_q;
    logic [7:0] adc_pt_q;
    logic [7:0] dac_pt_q;
    logic [7:0] ch1_q;

    wire sel_mute = reg_addr_i == `CADTR_ADDR_MUTE;
    wire sel_adc = reg_addr_i == `CADTR_ADDR_ADC_PT;
    wire sel_dac = reg_addr_i == `CADTR_ADDR_DAC_PT;
    wire sel_ch1 = reg_addr_i == `CADTR_ADDR_CH1;
    wire sel_any = sel_mute | sel_adc | sel_dac | sel_ch1;

    // Reserved positions are masked off on write so they always read zero
    wire [7:0] mute_d = reg_wdata_i & `CADTR_MASK_MUTE;
    wire [7:0] adc_pt_d = reg_wdata_i & `CADTR_MASK_ADC_PT;
    wire [7:0] dac_pt_d = reg_wdata_i & `CADTR_MASK_DAC_PT;
    // Values 2 and 3 are forbidden; stored as written, software owns that
    wire [7:0] ch1_d = reg_wdata_i & `CADTR_MASK_CH1;

    wire [7:0] rdata_d = sel_mute ? mute_q :
                         sel_adc ? adc_pt_q :
                         sel_dac ? dac_pt_q :
                         sel_ch1 ? ch1_q : 8'h00;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mute_q <= `CADTR_RESET_VAL;
            adc_pt_q <= `CADTR_RESET_VAL;
            dac_pt_q <= `CADTR_RESET_VAL;
            ch1_q <= `CADTR_RESET_VAL;
        end
        else if (reg_wr_i)
        begin
            if (sel_mute)
                mute_q <= mute_d;
            if (sel_adc)
                adc_pt_q <= adc_pt_d;
            if (sel_dac)
                dac_pt_q <= dac_pt_d;
            if (sel_ch1)
                ch1_q <= ch1_d;
        end
    end

    // Read data is registered; unmapped addresses answer zero with hit low
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            reg_rdata_o <= 8'h00;
            reg_hit_o <= 1'b0;
        end
        else if (reg_rd_i)
        begin
            reg_rdata_o <= rdata_d;
            reg_hit_o <= sel_any;
        end
    end

    wire [1:0] mute_en_w = {mute_q[`CADTR_BIT_CH2_MUTE], mute_q[`CADTR_BIT_CH1_MUTE]};

    // Controls are registered copies so every output comes from a flip-flop
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            overload_mute_en_o <= '0;
            adc_tune_o <= '0;
            dac_tune_o <= '0;
            ch1_cfg_o <= '0;
        end
        else
        begin
            overload_mute_en_o <= mute_en_w;
            adc_tune_o.adc_modulator_half_rate <= adc_pt_q[`CADTR_BIT_MOD_HALF];
            adc_tune_o.adc_decimator_order_sel <= adc_pt_q[`CADTR_BIT_CIC_ORDER];
            adc_tune_o.adc_fir_skip <= adc_pt_q[`CADTR_BIT_FIR_SKIP];
            adc_tune_o.adc_economy_filter_en <= adc_pt_q[`CADTR_BIT_ECO_FILT];
            dac_tune_o.dac_modulator_half_rate <= dac_pt_q[`CADTR_BIT_MOD_HALF];
            dac_tune_o.dac_fir_segmenter_skip <= dac_pt_q[`CADTR_BIT_FIR_SKIP];
            dac_tune_o.dac_economy_filter_en <= dac_pt_q[`CADTR_BIT_ECO_FILT];
            dac_tune_o.dac_ref_current_halve <= dac_pt_q[`CADTR_BIT_IREF_HALVE];
            ch1_cfg_o.first_channel_input_type <=
                ch1_q[`CADTR_BIT_INSRC_HI:`CADTR_BIT_INSRC_LO];
            ch1_cfg_o.first_channel_range_sel <= ch1_q[`CADTR_BIT_RANGE];
            ch1_cfg_o.first_channel_bandwidth_sel <= ch1_q[`CADTR_BIT_BW];
        end
    end

    // Mute uses the live register so muting starts one cycle after the write
    cadtr_sample_mute i_cadtr_sample_mute (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .mute_en_i(mute_en_w),
        .recovering_i(overload_recovery_i),
        .samples_i(adc_samples_i),
        .samples_o(adc_samples_o)
    );

    // Holds by the write masks; guards against a mask edited out of step
    a_reserved_read_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (mute_q & ~`CADTR_MASK_MUTE) == 8'h00 && (adc_pt_q & ~`CADTR_MASK_ADC_PT) == 8'h00
        && (dac_pt_q & ~`CADTR_MASK_DAC_PT) == 8'h00 && (ch1_q & ~`CADTR_MASK_CH1) == 8'h00)
        else $error("reserved bit set");

    // A write lands at its own edge, with reserved positions dropped
    a_mute_write_lands: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (reg_wr_i && sel_mute) |=> mute_q == ($past(reg_wdata_i) & `CADTR_MASK_MUTE))
        else $error("mute register write lost");
    a_adc_write_lands: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (reg_wr_i && sel_adc) |=> adc_pt_q == ($past(reg_wdata_i) & `CADTR_MASK_ADC_PT))
        else $error("adc tune register write lost");
    a_dac_write_lands: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (reg_wr_i && sel_dac) |=> dac_pt_q == ($past(reg_wdata_i) & `CADTR_MASK_DAC_PT))
        else $error("dac tune register write lost");
    a_ch1_write_lands: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (reg_wr_i && sel_ch1) |=> ch1_q == ($past(reg_wdata_i) & `CADTR_MASK_CH1))
        else $error("channel 1 register write lost");
    // Unmapped writes must leave every register untouched
    a_unmapped_write_ignored: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (reg_wr_i && !sel_any) |=> $stable(mute_q) && $stable(adc_pt_q) && $stable(dac_pt_q)
        && $stable(ch1_q))
        else $error("unmapped write changed a register");

    // Controls trail their register by one edge
    a_mute_enable_follow: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (reg_wr_i && sel_mute) ##1 1'b1 |=>
        overload_mute_en_o == {$past(reg_wdata_i[3], 2), $past(reg_wdata_i[4], 2)})
        else $error("mute enables wrong");
    a_adc_clock_sel: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (reg_wr_i && sel_adc) ##2 !$past(reg_wr_i)
        |-> adc_tune_o.adc_modulator_half_rate == $past(reg_wdata_i[7], 2))
        else $error("adc clock select wrong");
    a_adc_order_sel: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        adc_tune_o.adc_decimator_order_sel == $past(adc_pt_q[6]))
        else $error("decimator order wrong");
    a_adc_fir_sel: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        adc_tune_o.adc_fir_skip == $past(adc_pt_q[5]) &&
        adc_tune_o.adc_economy_filter_en == $past(adc_pt_q[2]))
        else $error("adc filter select wrong");
    a_dac_controls: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        dac_tune_o == {$past(dac_pt_q[7]), $past(dac_pt_q[5]), $past(dac_pt_q[2]),
        $past(dac_pt_q[1])})
        else $error("dac controls wrong");
    a_ch1_controls: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ch1_cfg_o == {$past(ch1_q[7:6]), $past(ch1_q[1]), $past(ch1_q[0])})
        else $error("channel 1 config wrong");

    // Read data is the register as it stood at the strobe's edge
    a_read_mute_data: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (reg_rd_i && sel_mute) |=> reg_rdata_o == $past(mute_q) && reg_hit_o)
        else $error("mute register read wrong");
    a_read_adc_data: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (reg_rd_i && sel_adc) |=> reg_rdata_o == $past(adc_pt_q) && reg_hit_o)
        else $error("adc tune register read wrong");
    a_read_dac_data: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (reg_rd_i && sel_dac) |=> reg_rdata_o == $past(dac_pt_q) && reg_hit_o)
        else $error("dac tune register read wrong");
    a_read_ch1_data: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (reg_rd_i && sel_ch1) |=> reg_rdata_o == $past(ch1_q) && reg_hit_o)
        else $error("channel 1 register read wrong");
    a_unmapped_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (reg_rd_i && !sel_any) |=> reg_rdata_o == 8'h00 && !reg_hit_o)
        else $error("unmapped read not zero");

    // Read answer stands until the next read strobe
    a_read_data_holds: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !reg_rd_i |=> $stable(reg_rdata_o) && $stable(reg_hit_o))
        else $error("read data changed without a read");

    c_write_mute: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        reg_wr_i && sel_mute && reg_wdata_i[4]);
    c_read_back: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        reg_wr_i && sel_dac ##1 reg_rd_i && sel_dac);
    c_recovery_mute: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        mute_en_w[1] && overload_recovery_i[1]);
    c_unmapped_read: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        reg_rd_i && !sel_any ##1 !reg_hit_o);

endmodule

// ===== tb/cadtr_tuning_regs_tb_top.sv
// Self-checking bench of the codec tuning register group
`timescale 1ns/1ps
`include "cadtr_cfg.svh"
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module cadtr_tuning_regs_tb_top
    import cadtr_pkg::*;
;
logic clk_sys_i = 1'h0;
logic rst_i = 1'h1;
logic reg_wr_i = 1'h0;
logic reg_rd_i = 1'h0;
logic [7:0] reg_addr_i = 8'h00;
logic [7:0] reg_wdata_i = 8'h00;
logic [7:0] reg_rdata_o;
logic reg_hit_o;
logic [1:0] overload_recovery_i = 2'h0;
logic [1:0] overload_mute_en_o;
cadtr_samples_t adc_samples_i = '0;
cadtr_samples_t adc_samples_o, s_exp, s_chk;
cadtr_adc_tune_t adc_tune_o;
cadtr_dac_tune_t dac_tune_o;
cadtr_ch1_cfg_t ch1_cfg_o;
logic [7:0] m_mute = 8'h00, m_adc = 8'h00, m_dac = 8'h00, m_ch1 = 8'h00, v;
logic [7:0] addr_tab [4] = '{`CADTR_ADDR_MUTE, `CADTR_ADDR_ADC_PT, `CADTR_ADDR_DAC_PT,
    `CADTR_ADDR_CH1};
logic [31:0] lf = 32'h00000039;
logic run = 1'h0;
logic rd_seen = 1'h0;
logic [8:0] r_exp;
logic [8:0] rq [$];
cadtr_samples_t sq [$];
int miscompares = 0, tests_run = 0, cycles = 0, i, k;

always #20 clk_sys_i = ~clk_sys_i;

cadtr_tuning_regs i_cadtr_tuning_regs (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o),
    .overload_recovery_i(overload_recovery_i), .adc_samples_i(adc_samples_i),
    .adc_samples_o(adc_samples_o), .overload_mute_en_o(overload_mute_en_o),
    .adc_tune_o(adc_tune_o), .dac_tune_o(dac_tune_o), .ch1_cfg_o(ch1_cfg_o));

function logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction

function logic [8:0] exp_of(input logic [7:0] a);
    case (a)
        `CADTR_ADDR_MUTE: return {1'h1, m_mute};
        `CADTR_ADDR_ADC_PT: return {1'h1, m_adc};
        `CADTR_ADDR_DAC_PT: return {1'h1, m_dac};
        `CADTR_ADDR_CH1: return {1'h1, m_ch1};
        default: return 9'h000;
    endcase
endfunction

task tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
endtask

task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'h1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'h0;
endtask

task rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'h1;
    reg_addr_i <= a;
    rq.push_back(exp_of(a));
    @(posedge clk_sys_i);
    reg_rd_i <= 1'h0;
endtask

// Controls follow one edge after the register, so wait two falling edges
task chk_ctrl;
    repeat (2) @(negedge clk_sys_i);
    `CHK("mute enables", {m_mute[3], m_mute[4]}, overload_mute_en_o)
    `CHK("adc tune", {m_adc[7], m_adc[6], m_adc[5], m_adc[2]}, adc_tune_o)
    `CHK("dac tune", {m_dac[7], m_dac[5], m_dac[2], m_dac[1]}, dac_tune_o)
    `CHK("ch1 config", {m_ch1[7:6], m_ch1[1], m_ch1[0]}, ch1_cfg_o)
endtask

always @(posedge clk_sys_i)
begin
    lf <= nxt(lf);
    adc_samples_i <= {lf[23:0], lf[31:8], lf[0]};
    overload_recovery_i <= lf[27:26];
end

// Model sees the mute bits as they stand before this edge's write lands
always @(posedge clk_sys_i)
begin
    rd_seen <= reg_rd_i;
    if (run)
    begin
        s_exp = adc_samples_i;
        if (m_mute[4] && overload_recovery_i[0])
            s_exp.first_sample = '0;
        if (m_mute[3] && overload_recovery_i[1])
            s_exp.second_sample = '0;
        sq.push_back(s_exp);
    end
    if (reg_wr_i)
    begin
        case (reg_addr_i)
            `CADTR_ADDR_MUTE: m_mute <= reg_wdata_i & `CADTR_MASK_MUTE;
            `CADTR_ADDR_ADC_PT: m_adc <= reg_wdata_i & `CADTR_MASK_ADC_PT;
            `CADTR_ADDR_DAC_PT: m_dac <= reg_wdata_i & `CADTR_MASK_DAC_PT;
            `CADTR_ADDR_CH1: m_ch1 <= reg_wdata_i & `CADTR_MASK_CH1;
            default: ;
        endcase
    end
end

always @(negedge clk_sys_i)
begin
    if (rd_seen)
    begin
        r_exp = rq.pop_front();
        `CHK("read data", r_exp, {reg_hit_o, reg_rdata_o})
    end
    if (sq.size() > 0)
    begin
        s_chk = sq.pop_front();
        `CHK("samples", s_chk, adc_samples_o)
    end
end

always @(posedge clk_sys_i)
begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
        miscompares++;
        tally_and_finish();
    end
end

initial
begin
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    repeat (2) @(posedge clk_sys_i);
    run <= 1'h1;
    for (i = 0; i < 4; i++)
        rd(addr_tab[i]);
    chk_ctrl();
    $display("test reset values done");
    for (i = 0; i < 4; i++)
    begin
        for (k = 0; k < 8; k++)
        begin
            v = (k == 0) ? 8'hff : (k == 7) ? 8'h00 : lf[7:0];
            // Input type codes 2 and 3 are never programmed
            if (i == 3)
                v[7] = 1'h0;
            wr(addr_tab[i], v);
            rd(addr_tab[i]);
            chk_ctrl();
        end
        // Leave every field set, but keep the input type code legal
        v = (i == 3) ? 8'h7f : 8'hff;
        wr(addr_tab[i], v);
    end
    $display("test field access done");
    wr(8'h4c, 8'hff);
    wr(8'h51, 8'h00);
    rd(8'h4c);
    rd(8'h00);
    for (i = 0; i < 4; i++)
        rd(addr_tab[i]);
    chk_ctrl();
    $display("test unmapped access done");
    for (k = 0; k < 4; k++)
    begin
        wr(`CADTR_ADDR_MUTE, {3'h0, k[1:0], 3'h0});
        repeat (40) @(posedge clk_sys_i);
    end
    chk_ctrl();
    $display("test overload muting done");
    repeat (3) @(posedge clk_sys_i);
    tally_and_finish();
end
endmodule
